// File: pkg/gms_pkg.sv
// constants, types and register map of the gauge measurement sequencer
`default_nettype none
package gms_pkg;
  localparam int unsigned CLK_HZ             = 10_000_000;
  localparam int unsigned SEQ_HALF_MS        = 880;
  localparam int unsigned SEQ_HALF_CYCLES    = SEQ_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned BUS_LOW_SLEEP_MS   = 1500;
  localparam int unsigned BUS_LOW_SLEEP_CYCLES = BUS_LOW_SLEEP_MS * (CLK_HZ / 1000);
  localparam int unsigned DIVIDER_SETTLE_LEAD_MS = 8;
  localparam int unsigned DIVIDER_SETTLE_LEAD_CYCLES = DIVIDER_SETTLE_LEAD_MS * (CLK_HZ / 1000);
  localparam int unsigned CUR_LSB_UV         = 25;
  localparam int unsigned ACC_RANGE_UVH      = 204800;
  localparam int          ACC_LIMIT          = (ACC_RANGE_UVH * 3600) / ((CUR_LSB_UV * SEQ_HALF_MS) / 1000);
  localparam logic [6:0]  DEV_ADDR           = 7'h36;
  localparam logic [7:0]  ADDR_CONFIG        = 8'h01;
  localparam logic [7:0]  ADDR_AUX0_HI       = 8'h08;
  localparam logic [7:0]  ADDR_AUX0_LO       = 8'h09;
  localparam logic [7:0]  ADDR_AUX1_HI       = 8'h0A;
  localparam logic [7:0]  ADDR_AUX1_LO       = 8'h0B;
  localparam logic [7:0]  ADDR_VOLT_HI       = 8'h0C;
  localparam logic [7:0]  ADDR_VOLT_LO       = 8'h0D;
  localparam logic [7:0]  ADDR_CUR_HI        = 8'h0E;
  localparam logic [7:0]  ADDR_CUR_LO        = 8'h0F;
  localparam logic [7:0]  ADDR_TEMP_HI       = 8'h10;
  localparam logic [7:0]  ADDR_TEMP_LO       = 8'h11;
  localparam logic [7:0]  ADDR_CURRENT_OFFSET_BIAS          = 8'h12;
  localparam logic [7:0]  ADDR_SCALE         = 8'h13;
  localparam logic [7:0]  ADDR_ACC_HI        = 8'h14;
  localparam logic [7:0]  ADDR_ACC_LO        = 8'h15;
  localparam int unsigned CFG_TEMP_BIT       = 0;
  localparam int unsigned CFG_SLEEP_BIT      = 5;
  localparam int unsigned CFG_ACTIVE_BIT     = 7;
  localparam logic [7:0]  CONFIG_RESET       = 8'h00;
  localparam logic [7:0]  CURRENT_OFFSET_BIAS_RESET         = 8'h00;
  localparam logic [7:0]  SCALE_RESET        = 8'h00;
  localparam logic [15:0] RESULT_RESET       = 16'h0000;
  localparam logic [15:0] SAT_POS            = 16'h7FFF;
  localparam logic [15:0] SAT_NEG            = 16'h8000;
  localparam logic [12:0] VOLT_CODE_MAX      = 13'h0FFF;
  localparam int          CUR_MAX            = 2047;
  localparam int          CUR_MIN            = -2048;
  localparam logic [9:0]  CAL_SLOT           = 10'h3FF;

  typedef struct packed {
    logic [12:0]        cell_voltage_input;
    logic signed [12:0] current_sense_input;
    logic [10:0]        aux_input_zero;
    logic [10:0]        aux_input_one;
    logic signed [10:0] temp_code;
    logic signed [7:0]  adc_offset;
  } gms_raw_t;

  typedef enum logic [6:0] {
    GMS_IDLE  = 7'b0000001,
    GMS_ADDR  = 7'b0000010,
    GMS_AACK  = 7'b0000100,
    GMS_WRX   = 7'b0001000,
    GMS_WACK  = 7'b0010000,
    GMS_RDATA = 7'b0100000,
    GMS_RACK  = 7'b1000000
  } gms_bus_state_t;
endpackage
`default_nettype wire

// File: design/gms_gauge_sequencer.sv
// measurement sequencer, accumulator and two-wire register access of the gauge
`default_nettype none
module gms_gauge_sequencer
  import gms_pkg::*;
#(
  parameter int unsigned HALF_CYCLES  = SEQ_HALF_CYCLES,
  parameter int unsigned SLEEP_CYCLES = BUS_LOW_SLEEP_CYCLES,
  parameter int unsigned LEAD_CYCLES  = DIVIDER_SETTLE_LEAD_CYCLES
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  input  wire gms_raw_t          raw,
  input  wire logic              ocv_restart,
  output logic                   divider_supply_en,
  output logic                   power_active,
  output logic signed [15:0]     capacity_delta
);
  localparam int unsigned VOLT_AT = HALF_CYCLES / 4;
  localparam int unsigned AUX_BEG = HALF_CYCLES / 2;
  localparam int unsigned AUX_END = (HALF_CYCLES / 4) * 3;
  localparam int unsigned CUR_AT  = HALF_CYCLES - 1;

  logic                 scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic [7:0]           config_reg, current_offset_bias, capacity_scale;
  logic [15:0]          voltage_result, current_result, temp_result;
  logic [15:0]          aux_input_zero_result, aux_input_one_result;
  logic signed [26:0]   charge_accumulator;
  logic signed [7:0]    offset_corr;
  logic [31:0]          phase, low_cnt;
  logic                 aux_sel, power_sleep;
  logic [9:0]           conv_cnt;
  logic                 volt_done, aux_done, cur_done, cal;
  logic signed [13:0]   volt_corr;
  logic signed [14:0]   cur_biased;
  logic signed [11:0]   cur_sat;
  logic [15:0]          next_current;
  logic signed [27:0]   acc_sum;
  logic signed [35:0]   scaled;
  gms_bus_state_t       st;
  logic [7:0]           shreg, ptr, tx, rd_byte, lo_snap;
  logic [3:0]           bitcnt;
  logic                 rw, first_byte, nack, wr_en;
  logic [7:0]           wr_addr, wr_data;
  logic                 scl_rise, scl_fall, bus_start, bus_stop;

  // two-stage synchronisers on the bus pins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
    end
  end
  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop  = scl_s && scl_d && !sda_d && sda_s;

  // power mode
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      power_sleep <= 1'b0;
      low_cnt     <= 32'h0;
    end else if (power_sleep) begin
      low_cnt <= 32'h0;
      if (scl_s || sda_s)
        power_sleep <= 1'b0;
    end else if (config_reg[CFG_SLEEP_BIT] && !scl_s && !sda_s) begin
      if (low_cnt == SLEEP_CYCLES - 1) begin
        power_sleep <= 1'b1;
        low_cnt     <= 32'h0;
      end else begin
        low_cnt <= low_cnt + 32'h1;
      end
    end else begin
      low_cnt <= 32'h0;
    end
  end
  assign power_active = !power_sleep;

  // conversion sequence timebase
  always_ff @(posedge core_clk) begin
    if (!rst_n || power_sleep) begin
      phase    <= 32'h0;
      aux_sel  <= 1'b0;
      conv_cnt <= 10'h0;
    end else if (phase == CUR_AT) begin
      phase    <= 32'h0;
      aux_sel  <= !aux_sel;
      conv_cnt <= conv_cnt + 10'h1;
    end else begin
      phase <= phase + 32'h1;
    end
  end
  assign volt_done = !power_sleep && phase == VOLT_AT;
  assign aux_done  = !power_sleep && phase == AUX_END;
  assign cur_done  = !power_sleep && phase == CUR_AT;
  assign cal       = conv_cnt == CAL_SLOT;
  assign divider_supply_en = !power_sleep && phase + LEAD_CYCLES >= AUX_BEG && phase < AUX_END
                             && !(aux_sel && config_reg[CFG_TEMP_BIT]);

  // offset calibration
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      offset_corr <= 8'sh00;
    else if (cur_done && cal)
      offset_corr <= raw.adc_offset;
  end

  // voltage result
  assign volt_corr = $signed({1'b0, raw.cell_voltage_input}) - 14'(offset_corr);
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      voltage_result <= RESULT_RESET;
    else if (volt_done && !cal) begin
      if (volt_corr < 0)
        voltage_result <= RESULT_RESET;
      else if (volt_corr > $signed({1'b0, VOLT_CODE_MAX}))
        voltage_result <= SAT_POS;
      else
        voltage_result <= {1'b0, volt_corr[11:0], 3'h0};
    end
  end

  // current result, bias and clamp
  assign cur_biased = -15'(raw.current_sense_input) - 15'(offset_corr)
                      + 15'($signed(current_offset_bias));
  always_comb begin
    if (cur_biased > 15'(CUR_MAX)) begin
      cur_sat      = 12'(CUR_MAX);
      next_current = SAT_POS;
    end else if (cur_biased < 15'(CUR_MIN)) begin
      cur_sat      = 12'(CUR_MIN);
      next_current = SAT_NEG;
    end else begin
      cur_sat      = cur_biased[11:0];
      next_current = {cur_biased[11:0], 4'h0};
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      current_result <= RESULT_RESET;
    else if (cur_done && !cal)
      current_result <= next_current;
  end

  // aux and temperature results
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aux_input_zero_result <= RESULT_RESET;
      aux_input_one_result  <= RESULT_RESET;
      temp_result           <= RESULT_RESET;
    end else if (aux_done) begin
      if (!aux_sel)
        aux_input_zero_result <= {1'b0, raw.aux_input_zero, 4'h0};
      else if (config_reg[CFG_TEMP_BIT])
        temp_result <= {raw.temp_code, 5'h00};
      else
        aux_input_one_result <= {1'b0, raw.aux_input_one, 4'h0};
    end
  end

  // charge accumulator
  assign acc_sum = 28'(charge_accumulator) + 28'(cur_sat);
  always_ff @(posedge core_clk) begin
    if (!rst_n || ocv_restart)
      charge_accumulator <= 27'sh0;
    else if (cur_done && !cal) begin
      if (acc_sum > 28'(ACC_LIMIT))
        charge_accumulator <= 27'(ACC_LIMIT);
      else if (acc_sum < -28'(ACC_LIMIT))
        charge_accumulator <= -27'(ACC_LIMIT);
      else
        charge_accumulator <= acc_sum[26:0];
    end
  end
  assign scaled = 36'(charge_accumulator) * $signed({1'b0, capacity_scale});
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      capacity_delta <= 16'sh0;
    else
      capacity_delta <= scaled[34:19];
  end

  // host-writable registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      config_reg          <= CONFIG_RESET;
      current_offset_bias <= CURRENT_OFFSET_BIAS_RESET;
      capacity_scale      <= SCALE_RESET;
    end else if (wr_en) begin
      case (wr_addr)
        ADDR_CONFIG: config_reg <= {1'b0, wr_data[6:0]};
        ADDR_CURRENT_OFFSET_BIAS: current_offset_bias <= wr_data;
        ADDR_SCALE: capacity_scale <= wr_data;
        default: config_reg <= config_reg;
      endcase
    end
  end

  // register read mux
  always_comb begin
    case (ptr)
      ADDR_CONFIG: rd_byte = {power_active, config_reg[6:0]};
      ADDR_AUX0_HI: rd_byte = aux_input_zero_result[15:8];
      ADDR_AUX0_LO: rd_byte = aux_input_zero_result[7:0];
      ADDR_AUX1_HI: rd_byte = aux_input_one_result[15:8];
      ADDR_AUX1_LO: rd_byte = aux_input_one_result[7:0];
      ADDR_VOLT_HI: rd_byte = voltage_result[15:8];
      ADDR_VOLT_LO: rd_byte = voltage_result[7:0];
      ADDR_CUR_HI: rd_byte = current_result[15:8];
      ADDR_CUR_LO: rd_byte = current_result[7:0];
      ADDR_TEMP_HI: rd_byte = temp_result[15:8];
      ADDR_TEMP_LO: rd_byte = temp_result[7:0];
      ADDR_CURRENT_OFFSET_BIAS: rd_byte = current_offset_bias;
      ADDR_SCALE: rd_byte = capacity_scale;
      ADDR_ACC_HI: rd_byte = charge_accumulator[26:19];
      ADDR_ACC_LO: rd_byte = charge_accumulator[18:11];
      default: rd_byte = 8'h00;
    endcase
  end

  // two-wire slave, serves registers in either mode
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= GMS_IDLE;
      {shreg, ptr, tx, lo_snap, wr_addr, wr_data} <= 48'h0;
      bitcnt <= 4'h0;
      {rw, first_byte, nack, wr_en, sda_oe} <= 5'h0;
    end else begin
      wr_en <= 1'b0;
      if (bus_stop) begin
        st     <= GMS_IDLE;
        sda_oe <= 1'b0;
      end else if (bus_start) begin
        st     <= GMS_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (st == GMS_ADDR || st == GMS_WRX) begin
          shreg  <= {shreg[6:0], sda_s};
          bitcnt <= bitcnt + 4'h1;
        end else if (st == GMS_RDATA)
          bitcnt <= bitcnt + 4'h1;
        else if (st == GMS_RACK)
          nack <= sda_s;
      end else if (scl_fall) begin
        case (st)
          GMS_ADDR: if (bitcnt == 4'h8) begin
            if (shreg[7:1] == DEV_ADDR) begin
              sda_oe     <= 1'b1;
              rw         <= shreg[0];
              first_byte <= 1'b1;
              st         <= GMS_AACK;
            end else
              st <= GMS_IDLE;
          end
          GMS_WRX: if (bitcnt == 4'h8) begin
            sda_oe <= 1'b1;
            st     <= GMS_WACK;
            if (first_byte)
              ptr <= shreg;
            else begin
              wr_en   <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              ptr     <= ptr + 8'h1;
            end
            first_byte <= 1'b0;
          end
          GMS_WACK: begin
            sda_oe <= 1'b0;
            bitcnt <= 4'h0;
            st     <= GMS_WRX;
          end
          GMS_AACK, GMS_RACK: begin
            if (st == GMS_AACK && !rw) begin
              sda_oe <= 1'b0;
              bitcnt <= 4'h0;
              st     <= GMS_WRX;
            end else if (st == GMS_RACK && nack) begin
              sda_oe <= 1'b0;
              st     <= GMS_IDLE;
            end else begin
              if (!ptr[0] && ptr >= ADDR_AUX0_HI && ptr <= ADDR_ACC_LO && ptr != ADDR_CURRENT_OFFSET_BIAS) begin
                lo_snap <= (ptr == ADDR_AUX0_HI) ? aux_input_zero_result[7:0] :
                           (ptr == ADDR_AUX1_HI) ? aux_input_one_result[7:0] :
                           (ptr == ADDR_VOLT_HI) ? voltage_result[7:0] :
                           (ptr == ADDR_CUR_HI) ? current_result[7:0] :
                           (ptr == ADDR_TEMP_HI) ? temp_result[7:0] :
                           charge_accumulator[18:11];
                tx <= rd_byte;
              end else if (ptr[0] && ptr > ADDR_AUX0_HI && ptr <= ADDR_ACC_LO && ptr != ADDR_SCALE)
                tx <= lo_snap;
              else
                tx <= rd_byte;
              sda_oe <= (ptr[0] && ptr > ADDR_AUX0_HI && ptr <= ADDR_ACC_LO && ptr != ADDR_SCALE)
                        ? !lo_snap[7] : !rd_byte[7];
              ptr    <= ptr + 8'h1;
              bitcnt <= 4'h0;
              st     <= GMS_RDATA;
            end
          end
          GMS_RDATA: if (bitcnt == 4'h8) begin
            sda_oe <= 1'b0;
            st     <= GMS_RACK;
          end else begin
            sda_oe <= !tx[3'(7 - bitcnt)];
          end
          GMS_IDLE: sda_oe <= 1'b0;
          default: st <= GMS_IDLE;
        endcase
      end
    end
  end
  assign sda_out = 1'b0;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_bus_low_run;
    !power_sleep && config_reg[CFG_SLEEP_BIT] && !scl_s && !sda_s;
  endsequence
  property p_sleep_entry;
    $rose(power_sleep) |-> $past(low_cnt) == SLEEP_CYCLES - 1 && $past(config_reg[CFG_SLEEP_BIT]);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered early");
  property p_no_sleep_when_barred;
    !config_reg[CFG_SLEEP_BIT] && !power_sleep |=> !power_sleep;
  endproperty
  a_no_sleep_when_barred: assert property (p_no_sleep_when_barred) else $error("sleep while barred");
  property p_wake;
    power_sleep && (scl_s || sda_s) |=> !power_sleep ##1 phase == 32'h1;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on bus high");
  property p_sleep_idle;
    power_sleep |-> !volt_done && !cur_done && !aux_done && !divider_supply_en;
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("activity in sleep");
  property p_vout_temp;
    aux_sel && config_reg[CFG_TEMP_BIT] |-> !divider_supply_en;
  endproperty
  a_vout_temp: assert property (p_vout_temp) else $error("divider on for temperature");
  property p_vout_lead;
    aux_done && !(aux_sel && config_reg[CFG_TEMP_BIT]) |-> $past(divider_supply_en);
  endproperty
  a_vout_lead: assert property (p_vout_lead) else $error("divider off at aux end");
  property p_volt_sat;
    volt_done && !cal && volt_corr > $signed({1'b0, VOLT_CODE_MAX}) |=> voltage_result == SAT_POS;
  endproperty
  a_volt_sat: assert property (p_volt_sat) else $error("voltage not saturated");
  property p_cur_clamp;
    cur_done && !cal && cur_biased < 15'(CUR_MIN) |=> current_result == SAT_NEG;
  endproperty
  a_cur_clamp: assert property (p_cur_clamp) else $error("current not clamped");
  property p_cal_hold;
    cur_done && cal |=> $stable(current_result) && $stable(charge_accumulator);
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("result changed in calibration");
  sequence s_plain_acc;
    cur_done && !cal && !ocv_restart && acc_sum <= 28'(ACC_LIMIT) && acc_sum >= -28'(ACC_LIMIT);
  endsequence
  property p_acc;
    s_plain_acc |=> 28'(charge_accumulator) == $past(acc_sum);
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator sum wrong");
  property p_current_offset_bias_write;
    wr_en && wr_addr == ADDR_CURRENT_OFFSET_BIAS |=> current_offset_bias == $past(wr_data);
  endproperty
  a_current_offset_bias_write: assert property (p_current_offset_bias_write) else $error("bias write lost");
  property p_low_count;
    s_bus_low_run ##1 s_bus_low_run |-> low_cnt == $past(low_cnt) + 32'h1 || $rose(power_sleep);
  endproperty
  a_low_count: assert property (p_low_count) else $error("bus low count broken");
endmodule
`default_nettype wire

// File: testbench/gms_host_model.sv
// two-wire bus controller standing in for the host processor
`default_nettype none
module gms_host_model
  import gms_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sda_line,
  output var  logic scl_drv,
  output var  logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_drv = 1'b1;
    sda_low = 1'b0;
  end
  // one quarter of the 800 ns bus period
  task automatic q(input int n);
    repeat (2 * n) @(negedge core_clk);
  endtask
  task automatic bit_io(input logic b, output logic s);
    scl_drv = 1'b0;
    q(1);
    sda_low = !b;
    q(1);
    scl_drv = 1'b1;
    q(1);
    s = sda_line;
    q(1);
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(last, ack);
  endtask
  // start is (0,1), stop is (1,0): data moves while the clock is high
  task automatic edge_cond(input logic first, input logic second);
    scl_drv = 1'b0;
    q(1);
    sda_low = first;
    q(1);
    scl_drv = 1'b1;
    q(2);
    sda_low = second;
    q(2);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic [2:0] k;
    edge_cond(1'b0, 1'b1);
    xfer({dev, 1'b0}, 1'b1, r, k[0]);
    xfer(a, 1'b1, r, k[1]);
    xfer(d, 1'b1, r, k[2]);
    edge_cond(1'b1, 1'b0);
    ok = (k === 3'b000);
  endtask
  task automatic rd(input logic [7:0] a, input logic two, output logic [15:0] v);
    logic [7:0] r;
    logic       k;
    edge_cond(1'b0, 1'b1);
    xfer({DEV_ADDR, 1'b0}, 1'b1, r, k);
    xfer(a, 1'b1, r, k);
    edge_cond(1'b0, 1'b1);
    xfer({DEV_ADDR, 1'b1}, 1'b1, r, k);
    xfer(8'hFF, !two, v[15:8], k);
    v[7:0] = 8'h00;
    if (two) begin
      xfer(8'hFF, 1'b1, v[7:0], k);
    end
    edge_cond(1'b1, 1'b0);
  endtask
  // low pulls both lines down, release lets the pull-ups win
  task automatic hold_low(input logic low);
    scl_drv = !low;
    q(1);
    sda_low = low;
  endtask
endmodule
`default_nettype wire

// File: testbench/gms_gauge_sequencer_tb.sv
// self-checking bench of the gauge measurement sequencer
`default_nettype none
module gms_gauge_sequencer_tb
  import gms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned HALF = 400;
  localparam int unsigned LEAD = 20;
  logic               core_clk;
  logic               rst_n;
  logic               scl;
  logic               host_sda_low;
  wire logic          sda_line;
  logic               sda_out;
  logic               sda_oe;
  gms_raw_t           raw;
  logic               ocv_restart;
  logic               div_en;
  logic               power_active;
  logic signed [15:0] capacity_delta;
  int                 failures;
  int                 check_count;
  logic [15:0]        v;
  logic               ok;
  int                 n;

  // pull-up on the data line
  assign sda_line = !(host_sda_low || (sda_oe && !sda_out));

  gms_gauge_sequencer #(.HALF_CYCLES(HALF), .SLEEP_CYCLES(200), .LEAD_CYCLES(LEAD)) i_dut (
    .core_clk          (core_clk),
    .rst_n             (rst_n),
    .scl_in            (scl),
    .sda_in            (sda_line),
    .sda_out           (sda_out),
    .sda_oe            (sda_oe),
    .raw               (raw),
    .ocv_restart       (ocv_restart),
    .divider_supply_en (div_en),
    .power_active      (power_active),
    .capacity_delta    (capacity_delta)
  );

  gms_host_model i_host (
    .core_clk (core_clk),
    .sda_line (sda_line),
    .scl_drv  (scl),
    .sda_low  (host_sda_low)
  );

  always #50 core_clk = !core_clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic rd16(input logic [7:0] a, input logic [15:0] exp, input string what);
    i_host.rd(a, 1'b1, v);
    chk(what, exp, v);
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] exp, input string what);
    i_host.rd(a, 1'b0, v);
    chk(what, {8'h00, exp}, {8'h00, v[15:8]});
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    i_host.wr(DEV_ADDR, a, d, ok);
    chk_bit("write ack", 1'b1, ok);
  endtask
  // one full sequence: a periodic output gives a fixed count
  task automatic div_count(input int exp);
    n = 0;
    repeat (2 * HALF) begin
      @(negedge core_clk);
      if (div_en === 1'b1) begin
        n++;
      end
    end
    chk("divider on cycles", 16'(exp), 16'(n));
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge core_clk);
    failures++;
    stop_test();
  end

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    raw = '0;
    ocv_restart = 1'b0;
    failures = 0;
    check_count = 0;
    cyc(10);
    rst_n = 1'b1;
    cyc(4);
    rd8(ADDR_CONFIG, 8'h80, "config reset");
    rd8(ADDR_SCALE, SCALE_RESET, "scale reset");
    i_host.wr(7'h35, ADDR_CURRENT_OFFSET_BIAS, 8'h33, ok);
    chk_bit("foreign address ack", 1'b0, ok);
    rd8(ADDR_CURRENT_OFFSET_BIAS, CURRENT_OFFSET_BIAS_RESET, "bias reset");
    rd8(8'h30, 8'h00, "unmapped read");
    wr8(ADDR_CURRENT_OFFSET_BIAS, 8'h05);
    rd8(ADDR_CURRENT_OFFSET_BIAS, 8'h05, "bias readback");
    raw.cell_voltage_input = 13'h0800;
    raw.current_sense_input = 13'h1F9C;
    raw.aux_input_zero = 11'h123;
    raw.aux_input_one = 11'h456;
    raw.temp_code = 11'h7F8;
    cyc(4 * HALF);
    rd16(ADDR_VOLT_HI, 16'h4000, "voltage");
    rd16(ADDR_CUR_HI, 16'h0690, "current");
    rd16(ADDR_AUX0_HI, 16'h1230, "aux zero");
    rd16(ADDR_AUX1_HI, 16'h4560, "aux one");
    div_count(2 * (HALF / 4 + LEAD));
    wr8(ADDR_CONFIG, 8'h01);
    cyc(4 * HALF);
    rd16(ADDR_TEMP_HI, 16'hFF00, "temperature");
    div_count(HALF / 4 + LEAD);
    wr8(ADDR_CURRENT_OFFSET_BIAS, 8'h80);
    cyc(3 * HALF);
    rd16(ADDR_CUR_HI, 16'hFE40, "negative bias");
    raw.cell_voltage_input = 13'h1000;
    raw.current_sense_input = 13'h0FA0;
    cyc(3 * HALF);
    rd16(ADDR_VOLT_HI, SAT_POS, "voltage clamp");
    rd16(ADDR_CUR_HI, SAT_NEG, "discharge clamp");
    wr8(ADDR_CURRENT_OFFSET_BIAS, 8'h05);
    raw.current_sense_input = 13'h1060;
    cyc(3 * HALF);
    rd16(ADDR_CUR_HI, SAT_POS, "charge clamp");
    wr8(ADDR_CURRENT_OFFSET_BIAS, 8'h00);
    wr8(ADDR_SCALE, 8'hFF);
    ocv_restart = 1'b1;
    cyc(HALF);
    chk("delta after restart", 16'h0000, capacity_delta);
    rd16(ADDR_ACC_HI, 16'h0000, "accumulator cleared");
    ocv_restart = 1'b0;
    cyc(4 * HALF);
    chk_bit("charge raises delta", 1'b1, capacity_delta > 0);
    raw.current_sense_input = 13'h0FA0;
    cyc(10 * HALF);
    chk_bit("discharge lowers delta", 1'b1, capacity_delta < 0);
    i_host.hold_low(1'b1);
    cyc(300);
    chk_bit("no sleep when disallowed", 1'b1, power_active);
    i_host.hold_low(1'b0);
    wr8(ADDR_CONFIG, 8'h21);
    i_host.hold_low(1'b1);
    cyc(150);
    chk_bit("awake before delay", 1'b1, power_active);
    cyc(80);
    chk_bit("asleep after delay", 1'b0, power_active);
    div_count(0);
    chk_bit("still asleep", 1'b0, power_active);
    i_host.hold_low(1'b0);
    cyc(4);
    chk_bit("woken by bus", 1'b1, power_active);
    rd8(ADDR_CONFIG, 8'hA1, "config readback");
    stop_test();
  end
endmodule
`default_nettype wire
